/* asu_pkg.sv */
// Constants, register map and types of the async serial transmitter
package asu_pkg;

  // ****************************************
  // Register indices (byte address = 4 * index)
  // ****************************************
  localparam logic [5:0] IDX_LFC = 6'h13;
  localparam logic [5:0] IDX_TCR = 6'h14;
  localparam logic [5:0] IDX_EBC = 6'h15;
  localparam logic [5:0] IDX_PST = 6'h16;
  localparam logic [5:0] IDX_SST = 6'h17;
  localparam logic [5:0] IDX_BUF = 6'h18;
  localparam logic [5:0] IDX_BRS = 6'h19;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int LFC_EN = 6;
  localparam int LFC_INV = 5;
  localparam int LFC_M = 4;
  localparam int LFC_PEN = 1;
  localparam int LFC_PTY = 0;
  localparam int TCR_TIE = 7;
  localparam int TCR_TCIE = 6;
  localparam int TCR_TE = 3;
  localparam int TCR_SBK = 0;
  localparam int EBC_T8 = 6;
  localparam int EBC_TX_DMA_SELECT = 4;
  localparam int PST_TX_BUFFER_EMPTY_FLAG = 7;
  localparam int PST_TC = 6;
  localparam int PST_FE = 1;

  // ****************************************
  // Reset values and sizes
  // ****************************************
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [7:0] EBC_WMASK = 8'h7f;
  localparam logic [3:0] FRAME_BASE = 4'ha;
  localparam logic [3:0] PAR_POS8 = 4'h9;
  localparam logic [3:0] PAR_POS9 = 4'ha;
  localparam int FRAME_W = 12;
  localparam logic [11:0] FRAME_ONES = 12'hfff;
  localparam logic [11:0] FRAME_ZERO = 12'h000;
  localparam logic [3:0] CNT_LAST = 4'h1;
  localparam logic [23:0] RD_PAD = 24'h000000;

  // Baud unit: cycles per step of bit_rate_select
  localparam logic [15:0] BAUD_UNIT = 16'h0010;

  // ****************************************
  // Transmitter states
  // ****************************************
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_PRE = 4'b0010,
    ST_SHIFT = 4'b0100,
    ST_BRK = 4'b1000
  } asu_txst_t;

endpackage : asu_pkg

/* asu_baud.sv */
// Shared baud rate generator of the async serial unit
`timescale 1ns/1ps
module asu_baud
  import asu_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] rate_i,
  output logic tick_o
);

  typedef struct packed {
    logic [15:0] cnt;
    logic tick;
  } asu_baud_st_t;

  asu_baud_st_t q;
  asu_baud_st_t n;

  // ****************************************
  // Divider
  // ****************************************
  // shared bit timing
  always_comb
  begin
    n = q;
    n.tick = 1'b0;
    if (q.cnt == 16'h0000)
    begin
      // Period is (rate + 1) units; a new rate applies at the next wrap
      n.cnt = 16'((32'(rate_i) + 32'h1) * 32'(BAUD_UNIT) - 32'h1);
      n.tick = 1'b1;
    end
    else
    begin
      n.cnt = q.cnt - 16'h0001;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q <= '0;
    end
    else
    begin
      q <= n;
    end
  end

  assign tick_o = q.tick;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_tick_single: assert property (tick_o |=> !tick_o)
    else $error("baud tick longer than one cycle");

endmodule : asu_baud

/* asu_tx.sv */
// Async serial transmitter with Wishbone register slave
//
// Overview of operation
// - Characters carry 8 or 9 data bits; ninth comes from ninth_tx_bit.
// - A DMA write to char_buffer clears the empty flag without status read.
// - Setting tx_on starts transmission with a preamble of ones before data loads.
// - Start bit zero goes first, stop bit one goes last.
// - Empty flag sets when char_buffer hands its byte to the shifter.
// - With tx_irq_enable, a set empty flag raises CPU or DMA request.
// - tx_dma_select routes empty flag to DMA, needing tx_irq_enable too.
// - Line rests at logic one while nothing is shifting.
// - Clearing module_enable_bit releases the serial pin.
// - send_break_bit loads all-zero characters of the frame length.
// - Breaks repeat while set; after clearing, at least one one follows.
// - A received break sets framing_error_flag.
// - Idle character is all ones of frame length; preamble is one.
// - Clearing tx_on mid character finishes it, then line idles.
// - Toggling tx_on mid transmission queues one idle character.
// - output_invert inverts every transmitted level.
// - Complete flag sets when shifter and buffer idle; may interrupt.
// - Transmitter takes bit timing from a shared baud generator.
`timescale 1ns/1ps
module asu_tx
  import asu_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic dma_wr_i,
  input wire logic [7:0] dma_data_i,
  output logic dma_req_o,
  output logic irq_o,
  input wire logic rx_break_i,
  output logic serial_out_pin_o,
  output logic serial_out_oe_o
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [7:0] lfc;
    logic [7:0] tcr;
    logic [7:0] ebc;
    logic [7:0] brs;
    logic [7:0] cbuf;
    logic tx_buffer_empty_flag;
    logic fe;
    logic arm;
    logic pend;
    asu_txst_t state;
    logic [3:0] cnt;
    logic [11:0] sh;
    logic pin;
    logic ack;
    logic [7:0] rdat;
  } asu_tx_st_t;

  asu_tx_st_t q;
  asu_tx_st_t n;
  logic tick;
  logic tc;
  logic req;
  logic wr;
  logic rd;
  logic [5:0] idx;
  logic [7:0] wdat;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [3:0] asu_len(input logic m, input logic parity_enable);
    asu_len = FRAME_BASE + {3'h0, m} + {3'h0, parity_enable};
  endfunction : asu_len

  function automatic logic [11:0] asu_frame(input logic [7:0] d, input logic t8,
                                            input logic m, input logic parity_enable,
                                            input logic parity_odd_select);
    logic [11:0] f;
    logic [3:0] pos;
    f = FRAME_ONES;
    f[0] = 1'b0;
    f[8:1] = d;
    pos = PAR_POS8;
    if (m)
    begin
      f[9] = t8;
      pos = PAR_POS9;
    end
    if (parity_enable)
    begin
      f[pos] = (^d) ^ (m & t8) ^ parity_odd_select;
    end
    asu_frame = f;
  endfunction : asu_frame

  asu_baud u_baud (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .rate_i(q.brs),
    .tick_o(tick)
  );

  assign req = cyc_i & stb_i;
  assign idx = adr_i[7:2];
  assign wdat = dat_i[7:0];
  assign wr = req & ~q.ack & we_i & sel_i[0];
  assign rd = req & ~q.ack & ~we_i;

  assign tc = (q.state == ST_IDLE) & q.tx_buffer_empty_flag & ~q.pend & ~q.tcr[TCR_SBK];

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    n = q;
    n.ack = req & ~q.ack;

    // Register reads; status read arms the empty-flag clear
    if (rd)
    begin
      unique case (idx)
        IDX_LFC: n.rdat = q.lfc;
        IDX_TCR: n.rdat = q.tcr;
        IDX_EBC: n.rdat = q.ebc;
        IDX_PST:
        begin
          n.rdat = RST_REG;
          n.rdat[PST_TX_BUFFER_EMPTY_FLAG] = q.tx_buffer_empty_flag;
          n.rdat[PST_TC] = tc;
          n.rdat[PST_FE] = q.fe;
          n.arm = q.tx_buffer_empty_flag;
          n.fe = 1'b0;
        end
        IDX_BUF: n.rdat = q.cbuf;
        IDX_BRS: n.rdat = q.brs;
        default: n.rdat = RST_REG;
      endcase
    end

    if (wr)
    begin
      unique case (idx)
        IDX_LFC: n.lfc = wdat;
        IDX_TCR:
        begin
          n.tcr = wdat;
          if (wdat[TCR_TE] & ~q.tcr[TCR_TE])
          begin
            n.pend = 1'b1;
          end
        end
        IDX_EBC: n.ebc = wdat & EBC_WMASK;
        IDX_BUF:
        begin
          n.cbuf = wdat;
          if (q.arm)
          begin
            n.tx_buffer_empty_flag = 1'b0;
            n.arm = 1'b0;
          end
        end
        IDX_BRS: n.brs = wdat;
        default: n.brs = q.brs;
      endcase
    end

    if (dma_wr_i)
    begin
      n.cbuf = dma_data_i;
      n.tx_buffer_empty_flag = 1'b0;
      n.arm = 1'b0;
    end

    if (rx_break_i)
    begin
      n.fe = 1'b1;
    end

    // Transmitter acts on baud ticks only while enabled, so every bit is a whole period
    if (!n.lfc[LFC_EN])
    begin
      n.state = ST_IDLE;
      n.sh = FRAME_ONES;
      n.cnt = 4'h0;
    end
    else if (tick)
    begin
      if ((q.state != ST_IDLE) && (q.cnt != CNT_LAST))
      begin
        n.sh = {1'b1, q.sh[11:1]};
        n.cnt = q.cnt - 4'h1;
      end
      else
      begin
        if ((q.state == ST_BRK) && !n.tcr[TCR_SBK])
        begin
          n.pend = 1'b1;
        end
        n.cnt = asu_len(n.lfc[LFC_M], n.lfc[LFC_PEN]);
        if (!n.tcr[TCR_TE])
        begin
          n.state = ST_IDLE;
          n.sh = FRAME_ONES;
        end
        else if (n.tcr[TCR_SBK])
        begin
          n.state = ST_BRK;
          n.sh = FRAME_ZERO;
        end
        else if (n.pend)
        begin
          n.state = ST_PRE;
          n.sh = FRAME_ONES;
          n.pend = 1'b0;
        end
        else if (!n.tx_buffer_empty_flag)
        begin
          n.state = ST_SHIFT;
          n.sh = asu_frame(n.cbuf, n.ebc[EBC_T8], n.lfc[LFC_M],
                           n.lfc[LFC_PEN], n.lfc[LFC_PTY]);
          n.tx_buffer_empty_flag = 1'b1;
          n.arm = 1'b0;
        end
        else
        begin
          n.state = ST_IDLE;
          n.sh = FRAME_ONES;
        end
      end
    end

    n.pin = n.sh[0] ^ n.lfc[LFC_INV];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q.lfc <= RST_REG;
      q.tcr <= RST_REG;
      q.ebc <= RST_REG;
      q.brs <= RST_REG;
      q.cbuf <= RST_REG;
      q.tx_buffer_empty_flag <= 1'b1;
      q.fe <= 1'b0;
      q.arm <= 1'b0;
      q.pend <= 1'b0;
      q.state <= ST_IDLE;
      q.cnt <= 4'h0;
      q.sh <= FRAME_ONES;
      q.pin <= 1'b1;
      q.ack <= 1'b0;
      q.rdat <= RST_REG;
    end
    else
    begin
      q <= n;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign dat_o = {RD_PAD, q.rdat};
  assign ack_o = q.ack;
  assign serial_out_pin_o = q.pin;
  assign serial_out_oe_o = q.lfc[LFC_EN];
  assign irq_o = (q.tx_buffer_empty_flag & q.tcr[TCR_TIE] & ~q.ebc[EBC_TX_DMA_SELECT])
               | (tc & q.tcr[TCR_TCIE]);
  assign dma_req_o = q.tx_buffer_empty_flag & q.tcr[TCR_TIE] & q.ebc[EBC_TX_DMA_SELECT];

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_one_cycle: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");

  a_idle_line_high: assert property (
    (q.state == ST_IDLE) && $stable(q.lfc[LFC_INV]) |-> q.pin == !q.lfc[LFC_INV])
    else $error("idle line not at idle level");

  a_break_line_low: assert property (
    (q.state == ST_BRK) && $stable(q.lfc[LFC_INV]) |-> q.pin == q.lfc[LFC_INV])
    else $error("break line not at zero level");

  a_start_bit_zero: assert property (
    $rose(q.state == ST_SHIFT) |-> q.pin == q.lfc[LFC_INV])
    else $error("start bit not zero");

  // Clear and load may share a cycle, so the flag may never read low
  a_load_sets_empty: assert property (
    $rose(q.state == ST_SHIFT) |-> q.tx_buffer_empty_flag
      && $past(!q.tx_buffer_empty_flag || dma_wr_i || (wr && idx == IDX_BUF)))
    else $error("empty flag not set on load");

  a_dma_route: assert property (
    dma_req_o |-> q.tcr[TCR_TIE] && q.ebc[EBC_TX_DMA_SELECT] && !irq_o || tc && q.tcr[TCR_TCIE])
    else $error("dma request without both enables");

  a_irq_route: assert property (
    q.tx_buffer_empty_flag && q.tcr[TCR_TIE] && !q.ebc[EBC_TX_DMA_SELECT] |-> irq_o && !dma_req_o)
    else $error("empty flag not routed to cpu");

  a_complete_flag: assert property (
    tc |-> q.state == ST_IDLE && q.tx_buffer_empty_flag && !q.pend)
    else $error("complete flag while busy");

  a_release_pin: assert property (
    !q.lfc[LFC_EN] |-> !serial_out_oe_o && q.state == ST_IDLE && q.sh == FRAME_ONES)
    else $error("pin not released when disabled");

  a_preamble_queued: assert property (
    $rose(q.tcr[TCR_TE]) |-> q.pend || q.state == ST_PRE)
    else $error("tx_on rise did not queue idle");

  a_break_then_one: assert property (
    (q.state == ST_BRK) ##1 (q.state != ST_BRK) |-> q.pend || q.state == ST_PRE
      || !q.tcr[TCR_TE] || !q.lfc[LFC_EN])
    else $error("no trailing one after break");

endmodule : asu_tx

/* asu_rx_model.sv */
// Remote receiver model that samples the serial line
`timescale 1ns/1ps
module asu_rx_model (
  input wire logic clk_i,
  input wire logic line_i,
  input wire logic inv_i,
  input wire logic [3:0] nbits_i,
  output logic [11:0] frame_o,
  output int count_o
);
  logic [11:0] f;
  // Assumes a 16 clock bit, the fastest divider setting
  initial
  begin
    frame_o = 12'h000;
    count_o = 0;
    forever
    begin
      @(posedge clk_i);
      if ((line_i ^ inv_i) === 1'b0)
      begin
        f = 12'h000;
        repeat (8) @(posedge clk_i);
        // Mid bit recheck drops glitches when polarity flips
        if ((line_i ^ inv_i) === 1'b0)
        begin
          for (int i = 0; i < nbits_i; i++)
          begin
            f[i] = line_i ^ inv_i;
            if (i < nbits_i - 1)
              repeat (16) @(posedge clk_i);
          end
          frame_o = f;
          count_o++;
        end
      end
    end
  end
endmodule : asu_rx_model

/* asu_tx_tb_top.sv */
// Self-checking bench of the async serial transmitter
`timescale 1ns/1ps
module asu_tx_tb_top;
  import asu_pkg::*;
  logic clk_i, rst_i, cyc, stb, we, dma_wr, rx_brk, dreq, irq, pin, oe, ack;
  logic inv, m, parity_enable, parity_odd_select, t8;
  logic [7:0] adr, dma_d, r, d8, d2;
  logic [3:0] nb;
  logic [31:0] dat, dat_o;
  logic [11:0] frm;
  int failures, checks_done, cnt, n, n2;

  asu_tx uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(4'hf), .dat_i(dat), .dat_o(dat_o), .ack_o(ack),
    .dma_wr_i(dma_wr), .dma_data_i(dma_d), .dma_req_o(dreq), .irq_o(irq),
    .rx_break_i(rx_brk), .serial_out_pin_o(pin), .serial_out_oe_o(oe));

  asu_rx_model rxm (.clk_i(clk_i), .line_i(pin), .inv_i(inv), .nbits_i(nb),
    .frame_o(frm), .count_o(cnt));

  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task test_done;
    $display("Checks %0d, mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : test_done

  task chk(input string nm, input logic [11:0] s, input logic [11:0] e);
    checks_done++;
    if (s !== e)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  // Waits for ack without assuming any latency
  task bus(input logic w, input logic [5:0] ix, input logic [7:0] d);
    int k;
    k = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {ix, 2'b00};
    dat <= {24'h000000, d};
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (ack !== 1'b1 && k < 100);
    r = dat_o[7:0];
    if (k >= 100)
    begin
      failures++;
      test_done();
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask : bus

  task wfr;
    int k;
    k = 0;
    n = cnt;
    while (cnt == n && k < 4000)
    begin
      @(posedge clk_i);
      k++;
    end
    if (k >= 4000)
    begin
      failures++;
      test_done();
    end
  endtask : wfr

  // Frame as seen on the line, first bit in position 0
  function logic [11:0] expf(input logic [7:0] d);
    logic [11:0] f;
    logic p;
    f = 12'h000;
    f[8:1] = d;
    p = ^d ^ parity_odd_select;
    if (m)
    begin
      f[9] = t8;
      p = p ^ t8;
    end
    if (parity_enable)
      f[9 + m] = p;
    f[nb - 1] = 1'b1;
    return f;
  endfunction : expf

  initial
  begin
    repeat (100000) @(posedge clk_i);
    failures++;
    test_done();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    failures = 0;
    checks_done = 0;
    {cyc, stb, we, dma_wr, rx_brk, inv, m, parity_enable, parity_odd_select, t8} = 10'h000;
    adr = 8'h00;
    dat = 32'h00000000;
    dma_d = 8'h00;
    nb = 4'ha;
    void'($urandom(45));
    rst_i = 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    bus(1'b0, IDX_PST, 8'h00);
    chk("status", r & 8'hc2, 8'hc0);
    bus(1'b0, 6'h20, 8'h00);
    chk("unmapped", r, 8'h00);
    bus(1'b1, IDX_BRS, 8'h00);
    bus(1'b1, IDX_LFC, 8'h40);
    repeat (2) @(posedge clk_i);
    chk("oe", {oe, pin}, 2'b11);
    $display("Test reset done");
    for (int k = 0; k < 8; k++)
    begin
      {parity_odd_select, parity_enable, m} = k[2:0];
      t8 = 1'($urandom);
      inv = 1'($urandom);
      d8 = 8'($urandom);
      nb = 4'ha + m + parity_enable;
      bus(1'b1, IDX_LFC, {2'b01, inv, m, 2'b00, parity_enable, parity_odd_select});
      bus(1'b1, IDX_EBC, {1'b0, t8, 6'h00});
      bus(1'b1, IDX_TCR, 8'h00);
      bus(1'b1, IDX_TCR, 8'h08);
      bus(1'b0, IDX_PST, 8'h00);
      bus(1'b1, IDX_BUF, d8);
      n2 = 0;
      while (pin === ~inv && n2 < 400)
      begin
        @(posedge clk_i);
        n2++;
      end
      chk("preamble", n2 >= (nb - 1) * 16, 1'b1);
      wfr();
      chk("frame", frm, expf(d8));
      repeat (20) @(posedge clk_i);
      bus(1'b0, IDX_PST, 8'h00);
      chk("flags", {r & 8'hc0, pin}, {8'hc0, ~inv});
    end
    $display("Test formats done");
    // Toggle tx_on inside a frame, then clear it inside the next one
    d8 = 8'($urandom);
    d2 = 8'($urandom);
    bus(1'b0, IDX_PST, 8'h00);
    bus(1'b1, IDX_BUF, d8);
    n2 = 0;
    while (pin === ~inv && n2 < 400)
    begin
      @(posedge clk_i);
      n2++;
    end
    bus(1'b1, IDX_TCR, 8'h00);
    bus(1'b1, IDX_TCR, 8'h08);
    bus(1'b0, IDX_PST, 8'h00);
    bus(1'b1, IDX_BUF, d2);
    wfr();
    chk("frame1", frm, expf(d8));
    n2 = 0;
    while (pin === ~inv && n2 < 400)
    begin
      @(posedge clk_i);
      n2++;
    end
    chk("idlechar", n2 >= (nb - 1) * 16, 1'b1);
    bus(1'b1, IDX_TCR, 8'h00);
    wfr();
    chk("frame2", frm, expf(d2));
    n2 = cnt;
    repeat (300) @(posedge clk_i);
    chk("txoff", {cnt == n2, pin}, {1'b1, ~inv});
    $display("Test toggle done");
    {inv, m, parity_enable, parity_odd_select} = 4'h0;
    nb = 4'ha;
    d8 = 8'($urandom);
    bus(1'b1, IDX_LFC, 8'h40);
    bus(1'b1, IDX_EBC, 8'h10);
    bus(1'b1, IDX_TCR, 8'h80);
    chk("dmareq", {dreq, irq}, 2'b10);
    dma_wr <= 1'b1;
    dma_d <= d8;
    @(posedge clk_i);
    dma_wr <= 1'b0;
    @(posedge clk_i);
    chk("dmaclr", dreq, 1'b0);
    bus(1'b1, IDX_TCR, 8'h88);
    wfr();
    chk("dmadata", frm, expf(d8));
    bus(1'b1, IDX_EBC, 8'h00);
    chk("cpuirq", {dreq, irq}, 2'b01);
    bus(1'b1, IDX_TCR, 8'h48);
    repeat (20) @(posedge clk_i);
    chk("tcirq", irq, 1'b1);
    $display("Test requests done");
    bus(1'b1, IDX_TCR, 8'h09);
    wfr();
    chk("break", frm, 12'h000);
    bus(1'b0, IDX_PST, 8'h00);
    chk("tcbrk", r[6], 1'b0);
    bus(1'b1, IDX_TCR, 8'h08);
    n2 = 0;
    while (pin !== 1'b1 && n2 < 400)
    begin
      @(posedge clk_i);
      n2++;
    end
    repeat (15) @(posedge clk_i);
    chk("brkend", {n2 < 400, pin}, 2'b11);
    rx_brk <= 1'b1;
    @(posedge clk_i);
    rx_brk <= 1'b0;
    bus(1'b0, IDX_PST, 8'h00);
    chk("fe", r[1], 1'b1);
    bus(1'b0, IDX_PST, 8'h00);
    chk("feclr", r[1], 1'b0);
    bus(1'b1, IDX_LFC, 8'h00);
    repeat (2) @(posedge clk_i);
    chk("oeoff", oe, 1'b0);
    $display("Test break done");
    test_done();
  end
endmodule : asu_tx_tb_top
